// [qco_output.sv]
// quadrature (A/B/marker) and three-phase commutation output generator
// angle samples and configuration come from logic on the same clock
//
// How it works
// [R1] zero marker is emitted at zero; width picked by zero_marker_width_select.
// [R2] before power_on_done the pins show the error-reporting levels.
// [R3] after power-on the output steps the shorter way to the angle.
// [R4] catch-up lasts at most 180 deg / R times the dwell time.
// [R5] dwell code zero: no catch-up, output jumps straight to position.
// [R6] rising marker edge marks zero going up, falling edge going down.
// [R7] marker width and shift follow resolution and width option.
// [R8] dwell limiting is on only when the 6-bit dwell code is nonzero.
// [R9] each quadrature state holds at least the dwell time when limiting.
// [R10] jumps are walked through every Gray state at dwell rate.
// [R11] new angle samples arrive every 1 us and update the target.
// [R12] dwell_limit_active_flag is high whenever a step is being held back.
// [R13] dwell time is 0.125 us times (code + 1).
// [R14] while limited, edges are paced by dwell time, not rotation rate.
// [R15] reversal with hysteresis is back-filled at dwell rate.
// [R16] commutation supports 1 to 16 pole pairs.
// [R17] commutation uses primary or secondary angle as selected.
// [R18] each commutation pin toggles when the angle crosses its edge.
// [R19] commutation uses the hysteresis-compensated angle.
// [R20] quadrature states 00,01,11,10; one phase changes per step.
// [R21] receiver counts up on B-before-A, down on A-before-B, other jumps go to bad; the 16-bit count wraps at 65536.
// [R22] output_protocol_select picks quadrature or commutation on the pins.
// [R23] output_polarity_invert inverts all three pins in both modes.
// [R24] an internal position accumulator is compared to each sample.
// [R25] the dwell flag clears when no transition is being held back.
`timescale 1ns/1ps
`include "qco_map.svh"

module qco_output
   import qco_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [15:0] angle_primary,
   input wire logic [15:0] angle_secondary,
   input wire logic angle_valid,
   input wire logic power_on_done,
   input wire logic [2:0] error_levels,
   input wire logic output_protocol_select,
   input wire logic output_polarity_invert,
   input wire logic output_channel_select,
   input wire logic [3:0] output_resolution_code,
   input wire logic [5:0] encoder_min_dwell_code,
   input wire logic [1:0] zero_marker_width_select,
   output logic out_a,
   output logic out_b,
   output logic out_i,
   output logic dwell_limit_active_flag,
   output logic catchup_active
);

   // ==========================================================
   // configuration decode
   logic [15:0] angle_sel;
   logic [3:0] res_shift;
   logic [13:0] pos_mask;
   logic [13:0] half_turn;
   logic dwell_en;
   logic [9:0] dwell_cycles;
   logic [31:0] dwell_ps;

   always_comb begin
      angle_sel = output_channel_select ? angle_secondary : angle_primary; // [R17]
      // codes outside the quadrature table clamp to the nearest row
      if (output_resolution_code < `QCO_RES_SHIFT_MIN) begin
         res_shift = `QCO_RES_SHIFT_MIN;
      end else if (output_resolution_code > `QCO_RES_SHIFT_MAX) begin
         res_shift = `QCO_RES_SHIFT_MAX;
      end else begin
         res_shift = output_resolution_code;
      end
      pos_mask = 14'h3fff >> (res_shift - 4'h2);
      half_turn = 14'h2000 >> (res_shift - 4'h2);
      dwell_en = (encoder_min_dwell_code != 6'h00); // [R8]
      // least time: round up to whole clock cycles
      dwell_ps = (32'(encoder_min_dwell_code) + 32'd1) * `QCO_DWELL_STEP_PS; // [R13]
      // code 63 needs 800 cycles, so the count is ten bits wide
      dwell_cycles = 10'((dwell_ps + `QCO_CLK_PERIOD_PS - 32'd1) / `QCO_CLK_PERIOD_PS);
   end

   // ==========================================================
   // target sampling and position accumulator
   qco_phase_e phase_r, phase_nxt;
   qco_pos_t pos_r, pos_nxt;
   qco_pos_t target_r, target_nxt;
   logic [9:0] cnt_r, cnt_nxt;
   logic flag_r, flag_nxt;
   qco_pos_t diff;
   logic pending;
   logic step_ok;
   logic go_down;

   always_comb begin
      target_nxt = target_r;
      if (angle_valid) begin
         target_nxt = 14'(angle_sel >> res_shift) & pos_mask; // [R11]
      end
      diff = (target_r - pos_r) & pos_mask; // [R24]
      pending = (diff != 14'h0000);
      go_down = (diff >= half_turn); // [R3]
      step_ok = (cnt_r >= dwell_cycles); // [R9] [R14]
      phase_nxt = phase_r;
      pos_nxt = pos_r;
      cnt_nxt = (cnt_r == `QCO_DWELL_CNT_MAX) ? cnt_r : cnt_r + 10'h001;
      flag_nxt = 1'b0; // [R25]
      case (phase_r)
         QCO_POWERON: begin
            if (power_on_done) begin // [R2]
               if (!dwell_en) begin
                  pos_nxt = target_r; // [R5]
                  phase_nxt = QCO_TRACK;
               end else begin
                  phase_nxt = QCO_CATCHUP;
                  cnt_nxt = 10'h000;
               end
            end
         end
         QCO_CATCHUP, QCO_TRACK: begin
            if (!dwell_en) begin
               pos_nxt = target_r;
               phase_nxt = QCO_TRACK;
            end else if (pending && step_ok) begin
               // one state per step keeps every Gray state visible
               pos_nxt = (go_down ? pos_r - 14'h0001 : pos_r + 14'h0001) & pos_mask; // [R10] [R15] [R4]
               cnt_nxt = 10'h001;
            end else if (pending) begin
               flag_nxt = 1'b1; // [R12]
            end else begin
               phase_nxt = QCO_TRACK; // [R3]
            end
         end
         default: begin
            phase_nxt = QCO_POWERON;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         phase_r <= QCO_POWERON;
         pos_r <= `QCO_POS_RESET;
         target_r <= `QCO_POS_RESET;
         cnt_r <= 10'h000;
         flag_r <= 1'b0;
      end else begin
         phase_r <= phase_nxt;
         pos_r <= pos_nxt;
         target_r <= target_nxt;
         cnt_r <= cnt_nxt;
         flag_r <= flag_nxt;
      end
   end

   // ==========================================================
   // commutation sectors
   logic [4:0] pole_pairs;
   logic [15:0] elec_angle;
   logic [18:0] sector_prod;
   logic [2:0] sector;
   logic [2:0] uvw;

   always_comb begin
      pole_pairs = 5'(output_resolution_code) + 5'h01; // [R16]
      elec_angle = 16'(angle_sel * pole_pairs); // [R19]
      sector_prod = 19'(elec_angle) * `QCO_SECTORS;
      sector = sector_prod[18:16];
      case (sector) // [R18]
         3'h0: uvw = 3'b100;
         3'h1: uvw = 3'b110;
         3'h2: uvw = 3'b010;
         3'h3: uvw = 3'b011;
         3'h4: uvw = 3'b001;
         3'h5: uvw = 3'b101;
         default: uvw = 3'b100;
      endcase
   end

   // ==========================================================
   // pin drive
   logic [2:0] pins_r, pins_nxt;
   logic [2:0] quad;
   logic marker;

   always_comb begin
      // marker covers states 0..zero_marker_width_select, so it rises entering 0 going up
      // and falls leaving 0 going down
      marker = (pos_r <= 14'(zero_marker_width_select)); // [R1] [R6] [R7]
      quad = {pos_r[1], pos_r[1] ^ pos_r[0], marker}; // [R20]
      if (phase_r == QCO_POWERON) begin
         pins_nxt = error_levels; // [R2]
      end else if (output_protocol_select) begin
         pins_nxt = uvw; // [R22]
      end else begin
         pins_nxt = quad;
      end
      pins_nxt = pins_nxt ^ {3{output_polarity_invert}}; // [R23]
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pins_r <= `QCO_OUT_RESET;
      end else begin
         pins_r <= pins_nxt;
      end
   end

   assign out_a = pins_r[2];
   assign out_b = pins_r[1];
   assign out_i = pins_r[0];
   assign dwell_limit_active_flag = flag_r;
   assign catchup_active = (phase_r == QCO_CATCHUP);

   // ==========================================================
   // catch-up length watch
   // restarts on a new target or a new setting, since the bound holds per target
   logic [23:0] settle_r, settle_nxt;
   logic [23:0] settle_max;
   logic [9:0] cfg_seen_r, cfg_seen_nxt;

   always_comb begin
      cfg_seen_nxt = {encoder_min_dwell_code, output_resolution_code};
      settle_max = 24'(half_turn) * 24'(dwell_cycles) + 24'h00_0002; // [R4]
      settle_nxt = 24'h00_0000;
      if ((phase_r == QCO_CATCHUP) && (target_nxt == target_r) && (cfg_seen_nxt == cfg_seen_r)) begin
         settle_nxt = (settle_r == 24'hff_ffff) ? settle_r : settle_r + 24'h00_0001;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         settle_r <= 24'h00_0000;
         cfg_seen_r <= 10'h000;
      end else begin
         settle_r <= settle_nxt;
         cfg_seen_r <= cfg_seen_nxt;
      end
   end

   // ==========================================================
   // checks
   sequence s_limited_step;
      (phase_r != QCO_POWERON) && dwell_en && (pos_r != $past(pos_r));
   endsequence

   sequence s_held_back;
      (phase_r != QCO_POWERON) && dwell_en && pending && !step_ok;
   endsequence

   a_dwell_hold: assert property (@(posedge clk) disable iff (!rst_n) // [R9]
      s_limited_step |-> $past(cnt_r) >= $past(dwell_cycles))
      else $error("quadrature state left before dwell time");

   a_flag_set: assert property (@(posedge clk) disable iff (!rst_n) // [R12]
      s_held_back |=> dwell_limit_active_flag)
      else $error("dwell flag missing while a step is held");

   a_flag_clear: assert property (@(posedge clk) disable iff (!rst_n) // [R25]
      !pending |=> !dwell_limit_active_flag)
      else $error("dwell flag high with nothing pending");

   a_gray_step: assert property (@(posedge clk) disable iff (!rst_n) // [R20]
      (phase_r != QCO_POWERON) && dwell_en ##1 (phase_r != QCO_POWERON) && dwell_en
      |-> pos_r == $past(pos_r) || ((pos_r - $past(pos_r)) & pos_mask) == 14'h0001
          || (($past(pos_r) - pos_r) & pos_mask) == 14'h0001)
      else $error("position moved more than one state");

   a_jump_direct: assert property (@(posedge clk) disable iff (!rst_n) // [R5]
      (phase_r != QCO_POWERON) && !dwell_en ##1 !dwell_en |-> pos_r == $past(target_r))
      else $error("output did not jump to target with dwell off");

   a_poweron_err: assert property (@(posedge clk) disable iff (!rst_n) // [R2]
      (phase_r == QCO_POWERON) |=> {out_a, out_b, out_i} == ($past(error_levels) ^ {3{$past(output_polarity_invert)}}))
      else $error("power-on pins do not show error levels");

   a_catchup_end: assert property (@(posedge clk) disable iff (!rst_n) // [R3]
      (phase_r == QCO_CATCHUP) && dwell_en && !pending |=> phase_r == QCO_TRACK)
      else $error("catch-up did not end at target");

   a_uvw_legal: assert property (@(posedge clk) disable iff (!rst_n) // [R18]
      (phase_r != QCO_POWERON) && output_protocol_select && !output_polarity_invert
      |=> ({out_a, out_b, out_i} != 3'b000) && ({out_a, out_b, out_i} != 3'b111))
      else $error("illegal commutation pattern");

   a_marker_zero: assert property (@(posedge clk) disable iff (!rst_n) // [R1]
      (phase_r != QCO_POWERON) && !output_protocol_select && (pos_r == 14'h0000)
      |=> out_i == !$past(output_polarity_invert))
      else $error("marker not active at zero position");

   a_step_pace: assert property (@(posedge clk) disable iff (!rst_n) // [R14]
      s_limited_step ##1 (phase_r != QCO_POWERON) |-> pos_r == $past(pos_r) || dwell_cycles <= 10'h001)
      else $error("back-to-back steps faster than dwell");

   a_catchup_bound: assert property (@(posedge clk) disable iff (!rst_n) // [R4]
      (phase_r == QCO_CATCHUP) |-> settle_r <= settle_max)
      else $error("catch-up ran past half a turn of dwell steps");

   // pins lag the position by one edge, so the marker edge shows one cycle on
   sequence s_wrap_up;
      (phase_r != QCO_POWERON) && ($past(phase_r) != QCO_POWERON) && !output_protocol_select
         && !output_polarity_invert && $stable(output_protocol_select) && $stable(output_polarity_invert)
         && $stable(zero_marker_width_select) && $stable(output_resolution_code)
         && (14'(zero_marker_width_select) < pos_mask)
         && (pos_r == 14'h0000) && ($past(pos_r) == pos_mask);
   endsequence

   sequence s_wrap_down;
      (phase_r != QCO_POWERON) && ($past(phase_r) != QCO_POWERON) && !output_protocol_select
         && !output_polarity_invert && $stable(output_protocol_select) && $stable(output_polarity_invert)
         && $stable(zero_marker_width_select) && $stable(output_resolution_code)
         && (14'(zero_marker_width_select) < pos_mask)
         && (pos_r == pos_mask) && ($past(pos_r) == 14'h0000);
   endsequence

   a_marker_rise: assert property (@(posedge clk) disable iff (!rst_n) // [R6]
      s_wrap_up |-> !out_i ##1 out_i)
      else $error("marker did not rise entering zero going up");

   a_marker_fall: assert property (@(posedge clk) disable iff (!rst_n) // [R6]
      s_wrap_down |-> out_i ##1 !out_i)
      else $error("marker did not fall leaving zero going down");
endmodule

// [qco_map.svh]
// timing counts and reset values for the quadrature / commutation output block
// assumes a 100 MHz clock; included by qco_output.sv only
`ifndef QCO_MAP_SVH
`define QCO_MAP_SVH

// ==========================================================
// timing
`define QCO_CLK_PERIOD_PS 32'd10000
`define QCO_DWELL_STEP_PS 32'd125000
`define QCO_DWELL_CNT_MAX 10'h3ff

// ==========================================================
// resolution code limits, reset values and commutation sector count
`define QCO_RES_SHIFT_MIN 4'h2
`define QCO_RES_SHIFT_MAX 4'he
`define QCO_POS_RESET 14'h0000
`define QCO_OUT_RESET 3'h0
`define QCO_SECTORS 19'h0_0006

`endif

// [qco_pkg.sv]
// types shared by the quadrature / commutation output block
// no assumptions beyond a SystemVerilog compiler
package qco_pkg;
   typedef enum logic [1:0] {
      QCO_POWERON,
      QCO_CATCHUP,
      QCO_TRACK
   } qco_phase_e;
   typedef logic [13:0] qco_pos_t;
endpackage

// [qco_rx_model.sv]
// receiver model: counts a/b quadrature steps, flags illegal jumps
// assumes un-inverted pins registered on clk
`timescale 1ns/1ps
module qco_rx_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic a,
   input wire logic b,
   output logic [15:0] count,
   output logic [7:0] bad,
   output logic [7:0] min_gap
);
   logic [1:0] prev;
   logic [7:0] gap;
   logic [1:0] ph;
   logic [1:0] pp;
   // gray state to phase index 00,01,11,10 -> 0..3
   assign ph = {a, a ^ b};
   assign pp = {prev[1], prev[1] ^ prev[0]};
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         prev <= 2'h0;
         count <= 16'h0000;
         bad <= 8'h00;
         min_gap <= 8'hff;
         gap <= 8'h00;
      end else begin
         prev <= {a, b};
         gap <= (gap == 8'hff) ? gap : gap + 8'h01;
         if ({a, b} != prev) begin
            gap <= 8'h00;
            // a saturated gap would wrap to zero in eight bits
            if (gap != 8'hff && gap + 8'h01 < min_gap) min_gap <= gap + 8'h01;
            if (ph == pp + 2'h1) count <= count + 16'h0001;
            else if (ph == pp - 2'h1) count <= count - 16'h0001;
            else bad <= bad + 8'h01;
         end
      end
   end
endmodule

// [quadrature_commutation_output_tb_top.sv]
// bench for qco_output: power-up, dwell stepping, marker, commutation
// assumes qco_rx_model listens on the a/b pins
`timescale 1ns/1ps
module quadrature_commutation_output_tb_top;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [15:0] ang_p = 16'h0000;
   logic [15:0] ang_s = 16'h0000;
   logic vld = 1'b0;
   logic pod = 1'b0;
   logic [2:0] err = 3'h0;
   logic proto = 1'b0;
   logic inv = 1'b0;
   logic chan = 1'b0;
   logic [3:0] res = 4'h4;
   logic [5:0] dwell = 6'h01;
   logic [1:0] zsel = 2'h0;
   logic a, b, i, flag, cu;
   logic seen_flag;
   logic [15:0] cnt;
   logic [7:0] bad, gap;
   logic [15:0] pins;
   int n_fail = 0;
   int cmp_count = 0;
   assign pins = {13'h0000, a, b, i};
   always #5 clk = ~clk;
   always @(posedge clk) begin
      if (!rst_n) seen_flag <= 1'b0;
      else if (flag === 1'b1) seen_flag <= 1'b1;
   end
   qco_output i_qco_output (.clk(clk), .rst_n(rst_n), .angle_primary(ang_p), .angle_secondary(ang_s),
      .angle_valid(vld), .power_on_done(pod), .error_levels(err), .output_protocol_select(proto),
      .output_polarity_invert(inv), .output_channel_select(chan), .output_resolution_code(res),
      .encoder_min_dwell_code(dwell), .zero_marker_width_select(zsel), .out_a(a), .out_b(b), .out_i(i),
      .dwell_limit_active_flag(flag), .catchup_active(cu));
   qco_rx_model i_qco_rx_model (.clk(clk), .rst_n(rst_n), .a(a), .b(b), .count(cnt), .bad(bad), .min_gap(gap));
   // ==========================================================
   // tasks
   task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic sample(input logic [15:0] ang);
      @(negedge clk);
      ang_p = ang;
      ang_s = ~ang;
      vld = 1'b1;
      @(negedge clk);
      vld = 1'b0;
   endtask
   task automatic do_reset(input logic [5:0] code);
      pod = 1'b0;
      rst_n = 1'b0;
      dwell = code;
      repeat (16) @(negedge clk);
      rst_n = 1'b1;
      repeat (2) @(negedge clk);
   endtask
   // bound sits far above the few dwell steps these scenarios need
   task automatic power_up(output logic st);
      int n;
      n = 0;
      pod = 1'b1;
      @(negedge clk);
      st = cu;
      while (cu === 1'b1 && n < 6150) begin
         @(negedge clk);
         n++;
      end
      repeat (3) @(negedge clk);
   endtask
   function automatic logic [2:0] uvw(input logic [15:0] ang, input int pp);
      logic [2:0] t [6] = '{3'h4, 3'h6, 3'h2, 3'h3, 3'h1, 3'h5};
      return t[(6 * ((ang * pp) % 65536)) / 65536];
   endfunction
   task automatic uvw_case(input logic [15:0] ang, input logic ch);
      chan = ch;
      sample(ang);
      repeat (3) @(negedge clk);
      check("uvw_pins", {13'h0000, uvw(ch ? ~ang : ang, int'(res) + 1) ^ {3{inv}}}, pins);
   endtask
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // ==========================================================
   // tests
   initial begin
      logic st;
      logic [15:0] mk_ang [3] = '{16'h0000, 16'h0030, 16'h0040};
      logic [15:0] mk_exp [3] = '{16'h0001, 16'h0005, 16'h0000};
      do_reset(6'h01);
      sample(16'h0060);
      power_up(st);
      check("catchup_start", 16'h0001, {15'h0000, st});
      check("catchup_end", 16'h0000, {15'h0000, cu});
      check("rx_count_up", 16'h0006, cnt);
      sample(16'h00b0);
      // five steps at 25 cycles each, plus pin and receiver latency
      repeat (140) @(negedge clk);
      check("rx_count_jump", 16'h000b, cnt);
      check("min_dwell", 16'h0019, {8'h00, gap});
      check("gray_only", 16'h0000, {8'h00, bad});
      check("flag_seen", 16'h0001, {15'h0000, seen_flag});
      check("flag_clear", 16'h0000, {15'h0000, flag});
      err = 3'h1;
      do_reset(6'h01);
      check("poweron_pins", 16'h0001, pins);
      inv = 1'b1;
      repeat (2) @(negedge clk);
      check("poweron_inv", 16'h0006, pins);
      inv = 1'b0;
      err = 3'h0;
      sample(16'hffd0);
      power_up(st);
      check("rx_count_down", 16'hfffd, cnt);
      sample(16'h0010);
      repeat (130) @(negedge clk);
      check("rx_count_wrap", 16'h0001, cnt);
      do_reset(6'h00);
      zsel = 2'h3;
      sample(16'h0660);
      power_up(st);
      check("no_catchup", 16'h0000, {15'h0000, st});
      check("jump_pins", 16'h0006, pins);
      for (int k = 0; k < 3; k++) begin
         sample(mk_ang[k]);
         repeat (3) @(negedge clk);
         check("marker", mk_exp[k], pins);
      end
      check("flag_off", 16'h0000, {15'h0000, seen_flag});
      proto = 1'b1;
      res = 4'h2;
      for (int k = 0; k < 6; k++) uvw_case(16'(k * 3641 + 100), 1'b0);
      res = 4'h0;
      uvw_case(16'h8000, 1'b0);
      res = 4'hf;
      uvw_case(16'h1234, 1'b0);
      inv = 1'b1;
      uvw_case(16'h2345, 1'b1);
      final_report();
   end
   initial begin
      #400000;
      n_fail++;
      final_report();
   end
endmodule
